// ### rtl/mbs_boot_host.sv
// boot host end: sends acknowledge word, image and END token to a tile
// assumes the user presents image words (length, program, CRC) on img_*
`timescale 1ns/1ps
module mbs_boot_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  mbs_link_if.host link,
  input wire logic start,
  input wire logic [31:0] ack_dest_word,
  input wire logic img_valid,
  input wire logic [31:0] img_data,
  input wire logic img_last,
  output logic img_ready,
  output logic busy,
  output logic done,
  output logic ack_seen
);
  import mbs_pkg::*;

  typedef enum {H_IDLE, H_ACKW, H_IMG, H_END, H_WAIT} mbs_host_e;

  mbs_host_e state;
  logic want_ack;
  wire sent = link.dn_valid && link.dn_ready;
  wire got_end = link.up_valid && link.up_ready;

  // host sequence, one word in flight at a time
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= H_IDLE;
      link.dn_valid <= 1'b0;
      link.dn_ctrl <= 1'b0;
      link.dn_data <= '0;
      link.up_ready <= 1'b1;
      img_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ack_seen <= 1'b0;
      want_ack <= 1'b0;
    end else begin
      done <= 1'b0;
      ack_seen <= got_end;
      case (state)
        H_IDLE: begin
          if (start) begin
            link.dn_valid <= 1'b1;
            link.dn_ctrl <= 1'b0;
            link.dn_data <= ack_dest_word;
            want_ack <= (ack_dest_word != NULL_CHANEND);
            busy <= 1'b1;
            state <= H_ACKW;
          end
        end
        H_ACKW: begin
          if (sent) begin
            link.dn_valid <= 1'b0;
            img_ready <= 1'b1;
            state <= H_IMG;
          end
        end
        H_IMG: begin
          if (link.dn_valid) begin
            if (sent) begin
              link.dn_valid <= 1'b0;
              img_ready <= 1'b1;
            end
          end else if (img_valid && img_ready) begin
            link.dn_valid <= 1'b1;
            link.dn_data <= img_data;
            img_ready <= 1'b0;
            if (img_last) state <= H_END;
          end
        end
        H_END: begin
          if (link.dn_valid) begin
            if (sent) begin
              link.dn_valid <= 1'b0;
              if (link.dn_ctrl) state <= H_WAIT;
            end
          end else begin
            link.dn_valid <= 1'b1;
            link.dn_ctrl <= 1'b1;
            link.dn_data <= END_TOKEN;
          end
        end
        H_WAIT: begin
          if (got_end || !want_ack) begin
            link.dn_ctrl <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // mbs_boot_host

// ### rtl/mbs_link_if.sv
// channel between a boot host and a tile boot end
// assumes both ends run on clk_sys; words carry a control-token flag
`timescale 1ns/1ps
interface mbs_link_if (
  input wire logic clk_sys
);
  logic dn_valid;
  logic dn_ready;
  logic dn_ctrl;
  logic [31:0] dn_data;
  logic up_valid;
  logic up_ready;
  logic [31:0] up_dest;
  modport tile (
    input dn_valid, dn_ctrl, dn_data, up_ready,
    output dn_ready, up_valid, up_dest
  );
  modport host (
    output dn_valid, dn_ctrl, dn_data, up_ready,
    input dn_ready, up_valid, up_dest
  );
endinterface // mbs_link_if

// ### rtl/mbs_pkg.sv
// constants shared by the tile boot end and the boot host end
// assumes one clock, clk_sys at 10 MHz, and a synchronous active-low reset
// How it works
// - reset pin low holds tile, pins float
// - after release count clocks, enable pulls
// - boot clock speed from two speed pins
// - boot source from three-bit source field
// - security bit 5 forces OTP boot
// - image opens with 32-bit word length
// - first channel word is acknowledge destination
// - image, CRC, then END token consumed
// - send END to destination, free, jump
// - secure boot reads OTP from word 0
// - OTP is four sectors of 512 words
// - security word loaded from OTP first
// - OTP content copied to SRAM, run first
// - OTP address via 16-bit port 0x100200
// - each tile picks its source alone
// - sleep tick adds programmable counter increment
package mbs_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RST_CYCLES = 750000;
  localparam int unsigned RTC_TICK_HZ = 31250;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [31:0] NULL_CHANEND = 32'h0000ff02;
  localparam logic [23:0] OTP_ADDR_PORT_ID = 24'h100200;
  localparam int unsigned OTP_SECTORS = 4;
  localparam int unsigned OTP_ROWS = 512;
  localparam int unsigned OTP_WORDS = OTP_SECTORS * OTP_ROWS;
  localparam logic [15:0] OTP_BOOT_ADDR = 16'h0000;
  localparam logic [15:0] OTP_SEC_ADDR = 16'h07ff;
  localparam int unsigned SEC_OTP_BIT = 5;
  localparam logic [2:0] SRC_CHAN = 3'h0;
  localparam logic [2:0] SRC_OTP = 3'h1;
  localparam logic [31:0] END_TOKEN = 32'h00000001;
endpackage

// ### rtl/mbs_tile_boot.sv
// tile boot sequencer with its channel receive fifo
// assumes OTP answers a read strobe with data one cycle later
`timescale 1ns/1ps

// small synchronous fifo, valid and ready on both sides
module mbs_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // honest flags from the occupancy count
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  // pointer wrap at depth
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // mbs_fifo

module mbs_tile_boot #(
  parameter int unsigned RST_COUNT = mbs_pkg::RST_CYCLES,
  parameter int unsigned RTC_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  mbs_link_if.tile link,
  input wire logic boot_speed_sel_lo,
  input wire logic boot_speed_sel_hi,
  input wire logic [2:0] boot_src_sel,
  output logic core_reset,
  output logic pins_hiz,
  output logic pull_en,
  output logic [1:0] boot_speed,
  output logic [2:0] boot_src,
  output logic [31:0] sec_reg,
  output logic otp_rd,
  output logic [15:0] otp_addr,
  output logic [23:0] otp_port_id,
  input wire logic [31:0] otp_rdata,
  output logic sram_we,
  output logic [15:0] sram_addr,
  output logic [31:0] sram_wdata,
  output logic chan0_free,
  output logic jump,
  output logic src_unsupported,
  input wire logic rtc_tick,
  input wire logic [RTC_W-1:0] rtc_incr,
  output logic [RTC_W-1:0] rtc_count
);
  import mbs_pkg::*;

  typedef enum {ST_HOLD, ST_SEC, ST_PICK, ST_CH_ACK, ST_CH_LEN, ST_CH_IMG, ST_CH_CRC,
    ST_CH_END, ST_CH_SEND, ST_OTP_LEN, ST_OTP_IMG, ST_JUMP, ST_RUN, ST_EXT} mbs_state_e;

  mbs_state_e state;
  logic [19:0] hold_cnt;
  logic [31:0] ack_dest;
  logic [31:0] img_len;
  logic [15:0] word_idx;
  logic rd_pend;
  logic f_valid;
  logic f_pop;
  logic [32:0] f_data;

  // channel words buffered before the sequencer
  mbs_fifo #(
    .WIDTH(33),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(link.dn_valid),
    .in_ready(link.dn_ready),
    .in_data({link.dn_ctrl, link.dn_data}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // decode of the buffered word and of the boot choice
  wire f_ctrl = f_data[32];
  wire [31:0] f_word = f_data[31:0];
  wire in_chan = (state == ST_CH_ACK) || (state == ST_CH_LEN) || (state == ST_CH_IMG) ||
    (state == ST_CH_CRC) || (state == ST_CH_END);
  assign f_pop = f_valid && in_chan;
  wire hold_done = (hold_cnt == 20'(RST_COUNT - 1));
  wire secure = sec_reg[SEC_OTP_BIT];
  wire pick_otp = secure || (boot_src == SRC_OTP);
  wire pick_chan = !secure && (boot_src == SRC_CHAN);
  wire [31:0] otp_max_len = 32'(OTP_WORDS - 2);
  wire [31:0] otp_len = (otp_rdata > otp_max_len) ? otp_max_len : otp_rdata;
  wire last_img = ({16'h0000, word_idx} == img_len - 32'h1);
  wire otp_can_issue = !otp_rd && !rd_pend;

  // boot sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_HOLD;
      hold_cnt <= '0;
      core_reset <= 1'b1;
      pins_hiz <= 1'b1;
      pull_en <= 1'b0;
      boot_speed <= '0;
      boot_src <= '0;
      sec_reg <= '0;
      otp_rd <= 1'b0;
      otp_addr <= '0;
      otp_port_id <= OTP_ADDR_PORT_ID;
      rd_pend <= 1'b0;
      sram_we <= 1'b0;
      sram_addr <= '0;
      sram_wdata <= '0;
      ack_dest <= '0;
      img_len <= '0;
      word_idx <= '0;
      chan0_free <= 1'b0;
      jump <= 1'b0;
      src_unsupported <= 1'b0;
      link.up_valid <= 1'b0;
      link.up_dest <= '0;
    end else begin
      sram_we <= 1'b0;
      jump <= 1'b0;
      otp_rd <= 1'b0;
      rd_pend <= otp_rd;
      case (state)
        ST_HOLD: begin
          hold_cnt <= hold_cnt + 20'h1;
          if (hold_done) begin
            pull_en <= 1'b1;
            boot_speed <= {boot_speed_sel_hi, boot_speed_sel_lo};
            boot_src <= boot_src_sel;
            state <= ST_SEC;
          end
        end
        ST_SEC: begin
          if (otp_can_issue) begin
            otp_rd <= 1'b1;
            otp_addr <= OTP_SEC_ADDR;
          end else if (rd_pend) begin
            sec_reg <= otp_rdata;
            state <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (pick_otp) state <= ST_OTP_LEN;
          else if (pick_chan) state <= ST_CH_ACK;
          else begin
            src_unsupported <= 1'b1;
            state <= ST_EXT;
          end
        end
        ST_CH_ACK: begin
          if (f_valid && !f_ctrl) begin
            ack_dest <= f_word;
            state <= ST_CH_LEN;
          end
        end
        ST_CH_LEN: begin
          if (f_valid && !f_ctrl) begin
            img_len <= f_word;
            word_idx <= '0;
            state <= (f_word == 32'h0) ? ST_CH_CRC : ST_CH_IMG;
          end
        end
        ST_CH_IMG: begin
          if (f_valid && !f_ctrl) begin
            sram_we <= 1'b1;
            sram_addr <= word_idx;
            sram_wdata <= f_word;
            word_idx <= word_idx + 16'h1;
            if (last_img) state <= ST_CH_CRC;
          end
        end
        ST_CH_CRC: begin
          if (f_valid && !f_ctrl) begin
            sram_we <= 1'b1;
            sram_addr <= img_len[15:0];
            sram_wdata <= f_word;
            state <= ST_CH_END;
          end
        end
        ST_CH_END: begin
          if (f_valid && f_ctrl) begin
            link.up_valid <= 1'b1;
            link.up_dest <= ack_dest;
            state <= ST_CH_SEND;
          end
        end
        ST_CH_SEND: begin
          if (link.up_ready) begin
            link.up_valid <= 1'b0;
            chan0_free <= 1'b1;
            state <= ST_JUMP;
          end
        end
        ST_OTP_LEN: begin
          if (otp_can_issue) begin
            otp_rd <= 1'b1;
            otp_addr <= OTP_BOOT_ADDR;
          end else if (rd_pend) begin
            img_len <= otp_len;
            word_idx <= '0;
            state <= ST_OTP_IMG;
          end
        end
        ST_OTP_IMG: begin
          if (otp_can_issue) begin
            otp_rd <= 1'b1;
            otp_addr <= OTP_BOOT_ADDR + word_idx + 16'h1;
          end else if (rd_pend) begin
            sram_we <= 1'b1;
            sram_addr <= word_idx;
            sram_wdata <= otp_rdata;
            word_idx <= word_idx + 16'h1;
            if ({16'h0000, word_idx} == img_len) state <= ST_JUMP;
          end
        end
        ST_JUMP: begin
          core_reset <= 1'b0;
          pins_hiz <= 1'b0;
          jump <= 1'b1;
          state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
        ST_EXT: state <= ST_EXT;
        default: state <= ST_HOLD;
      endcase
    end
  end

  // real-time counter stepped on each sleep tick
  always_ff @(posedge clk_sys) begin
    if (!rst_n) rtc_count <= '0;
    else if (rtc_tick) rtc_count <= rtc_count + rtc_incr;
  end
endmodule // mbs_tile_boot

// ### verification/mbs_chk.sv
// link checker: watches the channel between host end and tile end
// assumes plain inputs wired to the link interface signals
`timescale 1ns/1ps
module mbs_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dn_valid,
  input wire logic dn_ready,
  input wire logic dn_ctrl,
  input wire logic [31:0] dn_data,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic [31:0] up_dest
);
  import mbs_pkg::*;
  logic got;
  logic [31:0] ack_q;
  // handshake decodes
  wire dn_take = dn_valid && dn_ready;
  wire end_take = dn_take && dn_ctrl;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // first word taken after reset is the reply destination
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      got <= 1'b0;
      ack_q <= '0;
    end else if (dn_take && !got) begin
      got <= 1'b1;
      ack_q <= dn_data;
    end
  end
  a_rst_quiet: assert property (disable iff (1'b0) !rst_n |=> !dn_valid && !up_valid)
    else $error("link active in reset");
  a_dn_hold: assert property (dn_valid && !dn_ready |=> dn_valid && $stable(dn_data)
    && $stable(dn_ctrl))
    else $error("down word changed before taken");
  a_dn_gap: assert property (dn_take |=> !dn_valid)
    else $error("down words too close");
  a_end_code: assert property (dn_valid && dn_ctrl |-> dn_data == END_TOKEN)
    else $error("bad end token value");
  a_end_last: assert property (end_take |=> !dn_valid [*8])
    else $error("word after end token");
  a_end_reply: assert property (end_take |-> ##[1:40] up_valid)
    else $error("no end token back");
  a_reply_dest: assert property (up_valid |-> up_dest == ack_q)
    else $error("reply to wrong destination");
  a_up_hold: assert property (up_valid && !up_ready |=> up_valid && $stable(up_dest))
    else $error("reply dropped early");
  a_up_single: assert property (up_valid && up_ready |=> !up_valid [*4])
    else $error("reply repeated");
  a_up_open: assert property (up_ready)
    else $error("host not accepting reply");
  // main scenarios
  c_end: cover property (end_take);
  c_full: cover property (dn_valid && !dn_ready);
  c_reply: cover property (up_valid && up_ready && up_dest != NULL_CHANEND);
endmodule // mbs_chk

// ### verification/testbench.sv
// boot bench: host end and tile end joined by the link, otp modelled here
// assumes the tile hold count is shortened to RC clocks
`timescale 1ns/1ps
module testbench;
  import mbs_pkg::*;
  localparam int RC = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sp_lo = 1'b0;
  logic sp_hi = 1'b0;
  logic [2:0] src_sel = 3'h0;
  logic start = 1'b0;
  logic [31:0] ack_w = 32'h0;
  logic img_valid = 1'b0;
  logic img_last = 1'b0;
  logic [31:0] img_data = 32'h0;
  logic [31:0] otp_rdata = 32'h0;
  logic rtc_tick = 1'b0;
  logic [31:0] rtc_incr = 32'h0;
  logic core_reset, pins_hiz, pull_en, otp_rd, sram_we, chan0_free, jump, src_uns, img_ready;
  logic [1:0] boot_speed;
  logic [2:0] boot_src;
  logic [31:0] sec_reg, sram_wdata, rtc_count;
  logic [15:0] otp_addr, sram_addr;
  logic [23:0] otp_port_id;
  logic h_busy, h_done, h_ack;
  int n_done = 0;
  int n_ack = 0;
  logic [31:0] otp_mem [0:2047];
  logic [47:0] exp_q [$];
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  mbs_link_if u_mbs_link_if (.clk_sys(clk_sys));
  mbs_tile_boot #(.RST_COUNT(RC)) u_mbs_tile_boot (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(u_mbs_link_if), .boot_speed_sel_lo(sp_lo), .boot_speed_sel_hi(sp_hi),
    .boot_src_sel(src_sel), .core_reset(core_reset), .pins_hiz(pins_hiz), .pull_en(pull_en),
    .boot_speed(boot_speed), .boot_src(boot_src), .sec_reg(sec_reg), .otp_rd(otp_rd),
    .otp_addr(otp_addr), .otp_port_id(otp_port_id), .otp_rdata(otp_rdata),
    .sram_we(sram_we), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .chan0_free(chan0_free), .jump(jump), .src_unsupported(src_uns), .rtc_tick(rtc_tick),
    .rtc_incr(rtc_incr), .rtc_count(rtc_count));
  mbs_boot_host u_mbs_boot_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(u_mbs_link_if),
    .start(start), .ack_dest_word(ack_w), .img_valid(img_valid), .img_data(img_data),
    .img_last(img_last), .img_ready(img_ready), .busy(h_busy), .done(h_done), .ack_seen(h_ack));
  mbs_chk u_mbs_chk (.clk_sys(clk_sys), .rst_n(rst_n), .dn_valid(u_mbs_link_if.dn_valid),
    .dn_ready(u_mbs_link_if.dn_ready), .dn_ctrl(u_mbs_link_if.dn_ctrl),
    .dn_data(u_mbs_link_if.dn_data), .up_valid(u_mbs_link_if.up_valid),
    .up_ready(u_mbs_link_if.up_ready), .up_dest(u_mbs_link_if.up_dest));
  // otp answers a read one cycle later, scrambled otherwise
  always @(posedge clk_sys) otp_rdata <= otp_rd ? otp_mem[otp_addr[10:0]] : ~otp_rdata;
  // sram writes against the oldest note, jump pulses with no note pending, host pulses counted
  always @(posedge clk_sys) begin
    if (sram_we) chk_w(exp_q.size() ? exp_q.pop_front() : 48'hx, {sram_addr, sram_wdata});
    if (jump) chk_v("pending", 32'h0, 32'(exp_q.size()));
    if (h_done) n_done++;
    if (h_ack) n_ack++;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic chk_w(input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected sram exp %h got %h", e, g);
    end
  endtask
  task automatic chk_v(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one boot: mode pins, otp content, optional channel image
  task automatic boot(input logic [2:0] src, input logic sec, input logic [31:0] ack,
                      input int len);
    logic [31:0] img [0:7];
    logic [1:0] spd;
    logic chan;
    chan = (src == SRC_CHAN) && !sec;
    n_done = 0;
    n_ack = 0;
    spd = 2'($urandom);
    {sp_hi, sp_lo} <= spd;
    src_sel <= src;
    otp_mem[2047] = 32'(sec) << SEC_OTP_BIT;
    img[0] = 32'(len);
    for (int k = 1; k <= len + 1; k++) img[k] = $urandom;
    for (int k = 0; k <= len + 1; k++) otp_mem[k] = img[k];
    if (src <= SRC_OTP) for (int k = 1; k <= len + 1; k++) exp_q.push_back({16'(k - 1), img[k]});
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_v("hiz", 32'h1, 32'({pins_hiz, core_reset, pull_en} == 3'b110));
    rst_n <= 1'b1;
    fork
      begin
        repeat (RC) @(posedge clk_sys);
        chk_v("pull_early", 32'h0, 32'(pull_en));
        @(posedge clk_sys);
        chk_v("pull_en", 32'h1, 32'(pull_en));
        {sp_hi, sp_lo} <= ~spd;
        src_sel <= ~src;
      end
      if (chan) begin
        start <= 1'b1;
        ack_w <= ack;
        @(posedge clk_sys);
        start <= 1'b0;
        for (int k = 0; k <= len + 1; k++) begin
          img_valid <= 1'b1;
          img_data <= img[k];
          img_last <= (k == len + 1);
          do @(posedge clk_sys); while (img_ready !== 1'b1);
        end
        img_valid <= 1'b0;
      end
    join
    if (src > SRC_OTP && !sec) begin
      repeat (10) @(posedge clk_sys);
      chk_v("unsupported", 32'h1, 32'(src_uns));
    end else begin
      while (jump !== 1'b1) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      chk_v("released", 32'h0, 32'({core_reset, pins_hiz}));
      if (chan) chk_v("chan0_free", 32'h1, 32'(chan0_free));
    end
    chk_v("speed", 32'(spd), 32'(boot_speed));
    if (!sec) chk_v("src", 32'(src), 32'(boot_src));
    chk_v("sec_reg", otp_mem[2047], sec_reg);
    chk_v("port_id", 32'(OTP_ADDR_PORT_ID), 32'(otp_port_id));
    chk_v("host_done", 32'(chan), 32'(n_done));
    chk_v("ack_seen", 32'(chan), 32'(n_ack));
    chk_v("host_busy", 32'h0, 32'(h_busy));
  endtask
  initial begin
    logic [31:0] c0;
    void'($urandom(23));
    boot(SRC_CHAN, 1'b0, $urandom | 32'h00010000, 6);
    boot(SRC_CHAN, 1'b0, NULL_CHANEND, 0);
    boot(SRC_OTP, 1'b0, 32'h0, 3);
    boot(SRC_CHAN, 1'b1, 32'h0, 2);
    boot(3'h2, 1'b0, 32'h0, 1);
    rtc_incr <= $urandom;
    repeat (2) @(posedge clk_sys);
    c0 = rtc_count;
    repeat (3) begin
      rtc_tick <= 1'b1;
      @(posedge clk_sys);
      rtc_tick <= 1'b0;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    chk_v("rtc", c0 + 3 * rtc_incr, rtc_count);
    results();
  end
endmodule // testbench
